// [pkg/dpg_map.vh]
// constants for the dual address/gpio port block: register offsets, reset values, modes
// assumes a 32-bit axi4-lite slave where only the low 16 address bits are decoded
//
// Summary of operation
// RQ1 - decode registers on low 16 address bits; port a direction ffc0, data ffc2
// RQ2 - port a direction: 8-bit write-only, bit n sets pin n output when 1
// RQ3 - port a direction clears on reset and hardware standby, holds in software standby
// RQ4 - in software standby, port a output pins keep driving their present state
// RQ5 - port a data: 8-bit read/write output data, bit n for pin n
// RQ6 - port a read returns stored data bit where direction bit is 1
// RQ7 - port a read returns live pin level where direction bit is 0
// RQ8 - port a data clears on reset and hardware standby, holds in software standby
// RQ9 - modes 1 and 3: port a pins are address outputs, direction reads ones, unwritable
// RQ10 - mode 5: port a pin drives address when direction 1, else input
// RQ11 - mode 5 pins start as inputs; software sets direction for address output
// RQ12 - modes 6 and 7: port a pin output when direction 1, input otherwise
// RQ13 - modes 1 and 3: port b carries address 15..8, direction reads all ones
// RQ14 - mode 5: port b pin carries address bit when direction 1, else input
// RQ15 - modes 6 and 7: port b is generic per-pin input/output by direction
// RQ16 - port b direction write-only at ffc1, clears on reset/hw standby, holds otherwise
// RQ17 - port b output pins hold output state through software standby
// RQ18 - port b read returns data bit where direction bit is 1
// RQ19 - port b read returns actual pin level where direction bit is 0
// RQ20 - port b data read/write at ffc3, clears on reset/hw standby, holds in sw standby
// RQ21 - port b pull-up enable register read/write at ffd8, resets to zero
// RQ22 - pull-up on only if enable 1, direction 0, mode 5/6/7; off in reset/hw standby
// RQ23 - modes 1 and 3: port a pins carry address bits 7..0
// RQ24 - reading a write-only direction register returns all ones
`ifndef DPG_MAP_VH
`define DPG_MAP_VH

// ======================================================================
// register offsets, low 16 bits of the byte address
`define DPG_OFS_A_DIR 16'hFFC0
`define DPG_OFS_B_DIR 16'hFFC1
`define DPG_OFS_A_DATA 16'hFFC2
`define DPG_OFS_B_DATA 16'hFFC3
`define DPG_OFS_B_PULLUP 16'hFFD8

// ======================================================================
// reset values and the all-ones direction read value
`define DPG_RST_DIR 8'h00
`define DPG_RST_DATA 8'h00
`define DPG_RST_PULLUP 8'h00
`define DPG_READ_ONES 8'hFF

// ======================================================================
// operating mode codes
`define DPG_MODE_1 3'h1
`define DPG_MODE_3 3'h3
`define DPG_MODE_5 3'h5
`define DPG_MODE_6 3'h6
`define DPG_MODE_7 3'h7

// ======================================================================
// axi responses
`define DPG_RESP_OKAY 2'h0
`define DPG_RESP_SLVERR 2'h2

`endif

// [verilog/dpg_top.v]
// two 8-bit ports usable as address outputs or gpio, with axi4-lite register access
// assumes pins and mode/standby inputs are synchronous to aclk; standby inputs are levels
`timescale 1ns/100ps
`include "dpg_map.vh"

module dpg_top (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] op_mode,
  input wire hw_standby,
  input wire sw_standby,
  input wire [15:0] addr_bus,
  input wire [7:0] port_a_in,
  output reg [7:0] port_a_out,
  output reg [7:0] port_a_oe_n,
  input wire [7:0] port_b_in,
  output reg [7:0] port_b_out,
  output reg [7:0] port_b_oe_n,
  output reg [7:0] port_b_pullup_on,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ======================================================================
  // register storage
  reg [7:0] port_a_direction;
  reg [7:0] port_a_output_data;
  reg [7:0] port_b_direction;
  reg [7:0] port_b_output_data;
  reg [7:0] port_b_pullup_enable;

  // byte lane of a low-16 address: offsets are byte addresses, not word aligned
  function [1:0] lane_of;
    input [15:0] a;
    begin
      lane_of = a[1:0];
    end
  endfunction

  // register index from the low 16 address bits; 3'h7 means unmapped
  function [2:0] decode;
    input [15:0] a;
    begin
      if (a == `DPG_OFS_A_DIR) begin
        decode = 3'h0; // RQ1
      end else if (a == `DPG_OFS_B_DIR) begin
        decode = 3'h1; // RQ16
      end else if (a == `DPG_OFS_A_DATA) begin
        decode = 3'h2; // RQ1
      end else if (a == `DPG_OFS_B_DATA) begin
        decode = 3'h3; // RQ20
      end else if (a == `DPG_OFS_B_PULLUP) begin
        decode = 3'h4; // RQ21
      end else begin
        decode = 3'h7;
      end
    end
  endfunction

  wire addr_mode = (op_mode == `DPG_MODE_1) || (op_mode == `DPG_MODE_3);
  wire mode_5 = (op_mode == `DPG_MODE_5);
  wire gpio_mode = (op_mode == `DPG_MODE_6) || (op_mode == `DPG_MODE_7);

  // effective direction: forced ones in the address-only modes
  wire [7:0] dir_a_eff = addr_mode ? `DPG_READ_ONES : port_a_direction; // RQ9
  wire [7:0] dir_b_eff = addr_mode ? `DPG_READ_ONES : port_b_direction; // RQ13

  // ======================================================================
  // write channel: address and data latched independently, either order
  reg aw_held;
  reg w_held;
  reg [15:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [2:0] wr_sel = decode({aw_addr[15:2], 2'b00} | {14'h0000, lane_of(aw_addr)});
  wire [1:0] wr_lane = lane_of(aw_addr);
  wire [7:0] wr_byte = w_data[8 * wr_lane +: 8];
  wire wr_en = w_strb[wr_lane];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DPG_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[15:0]; // RQ1
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == 3'h7) ? `DPG_RESP_SLVERR : `DPG_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // registers: cleared by reset or hardware standby, held in software standby
  always @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      port_a_direction <= `DPG_RST_DIR; // RQ3 RQ11
      port_a_output_data <= `DPG_RST_DATA; // RQ8
      port_b_direction <= `DPG_RST_DIR; // RQ16
      port_b_output_data <= `DPG_RST_DATA; // RQ20
      port_b_pullup_enable <= `DPG_RST_PULLUP; // RQ21
    end else if (do_write && wr_en && !sw_standby) begin
      // direction writes are ignored in the address-only modes
      if (wr_sel == 3'h0 && !addr_mode) begin
        port_a_direction <= wr_byte; // RQ2 RQ9
      end else if (wr_sel == 3'h1 && !addr_mode) begin
        port_b_direction <= wr_byte; // RQ16 RQ13
      end else if (wr_sel == 3'h2) begin
        port_a_output_data <= wr_byte; // RQ5
      end else if (wr_sel == 3'h3) begin
        port_b_output_data <= wr_byte; // RQ20
      end else if (wr_sel == 3'h4) begin
        port_b_pullup_enable <= wr_byte; // RQ21
      end
    end
  end

  // ======================================================================
  // read channel: one cycle after the address is taken
  reg [7:0] rd_byte;
  wire [15:0] ar_low = s_axi_araddr[15:0];
  wire [2:0] rd_sel = decode(ar_low);

  always @* begin
    if (rd_sel == 3'h0 || rd_sel == 3'h1) begin
      rd_byte = `DPG_READ_ONES; // RQ24 RQ9 RQ13
    end else if (rd_sel == 3'h2) begin
      rd_byte = (dir_a_eff & port_a_output_data) | (~dir_a_eff & port_a_in); // RQ6 RQ7
    end else if (rd_sel == 3'h3) begin
      rd_byte = (dir_b_eff & port_b_output_data) | (~dir_b_eff & port_b_in); // RQ18 RQ19
    end else if (rd_sel == 3'h4) begin
      rd_byte = port_b_pullup_enable;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DPG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        // byte placed on its lane; other lanes read zero
        s_axi_rdata <= {24'h000000, rd_byte} << (8 * lane_of(ar_low));
        s_axi_rresp <= (rd_sel == 3'h7) ? `DPG_RESP_SLVERR : `DPG_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // pin drive: registered, so pins lag register and mode changes by one cycle
  reg [7:0] next_a_out;
  reg [7:0] next_a_oe_n;
  reg [7:0] next_b_out;
  reg [7:0] next_b_oe_n;

  always @* begin
    if (addr_mode) begin
      next_a_out = addr_bus[7:0]; // RQ23
      next_a_oe_n = 8'h00; // RQ9
      next_b_out = addr_bus[15:8]; // RQ13
      next_b_oe_n = 8'h00;
    end else if (mode_5) begin
      next_a_out = addr_bus[7:0]; // RQ10
      next_a_oe_n = ~port_a_direction; // RQ10 RQ11
      next_b_out = addr_bus[15:8]; // RQ14
      next_b_oe_n = ~port_b_direction; // RQ14
    end else if (gpio_mode) begin
      next_a_out = port_a_output_data; // RQ12
      next_a_oe_n = ~port_a_direction; // RQ12
      next_b_out = port_b_output_data; // RQ15
      next_b_oe_n = ~port_b_direction; // RQ15
    end else begin
      next_a_out = 8'h00;
      next_a_oe_n = 8'hFF;
      next_b_out = 8'h00;
      next_b_oe_n = 8'hFF;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      port_a_out <= 8'h00;
      port_a_oe_n <= 8'hFF;
      port_b_out <= 8'h00;
      port_b_oe_n <= 8'hFF;
      port_b_pullup_on <= 8'h00; // RQ22
    end else begin
      // software standby freezes pin values so output pins keep their state
      if (!sw_standby) begin
        port_a_out <= next_a_out;
        port_a_oe_n <= next_a_oe_n;
        port_b_out <= next_b_out;
        port_b_oe_n <= next_b_oe_n;
      end else begin
        port_a_out <= port_a_out; // RQ4
        port_b_out <= port_b_out; // RQ17
      end
      port_b_pullup_on <= (mode_5 || gpio_mode) ?
        (port_b_pullup_enable & ~port_b_direction) : 8'h00; // RQ22
    end
  end

endmodule // dpg_top

// [dv/dpg_pins.sv]
// board-side pin model: each pin's level from design drive, pull-up and outside level
// assumes oe_n low means the design drives the pin
`timescale 1ns/100ps
module dpg_pins (
  input wire [7:0] out,
  input wire [7:0] oe_n,
  input wire [7:0] pu,
  input wire [7:0] ext,
  output wire [7:0] lvl
);
  // ==========================================
  // released pins read high where pulled up, else the bench's level, never the last driven value
  assign lvl = (~oe_n & out) | (oe_n & pu) | (oe_n & ~pu & ext);
endmodule // dpg_pins

// [dv/dpg_chk.sv]
// port-level checks for dpg_top
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/100ps
module dpg_chk (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] op_mode,
  input wire hw_standby,
  input wire sw_standby,
  input wire [15:0] addr_bus,
  input wire [7:0] port_a_out,
  input wire [7:0] port_a_oe_n,
  input wire [7:0] port_b_out,
  input wire [7:0] port_b_oe_n,
  input wire [7:0] port_b_pullup_on,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid
);
  // ==========================================
  // helpers
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] raddr;
  wire run = !hw_standby && !sw_standby;
  wire m13 = op_mode == 3'h1 || op_mode == 3'h3;
  wire mapped = raddr inside {16'hFFC0, 16'hFFC1, 16'hFFC2, 16'hFFC3, 16'hFFD8};
  always_ff @(posedge aclk)
    if (!aresetn) raddr <= 16'h0000;
    else if (s_axi_arvalid && s_axi_arready) raddr <= s_axi_araddr[15:0];
  // ==========================================
  // assertions
  AST_A_ADDR: assert property (m13 && run |=>
    port_a_oe_n == 8'h00 && port_a_out == $past(addr_bus[7:0])) else $error("port a not address");
  AST_B_ADDR: assert property (m13 && run |=>
    port_b_oe_n == 8'h00 && port_b_out == $past(addr_bus[15:8])) else $error("port b not address");
  AST_FREEZE: assert property (sw_standby && !hw_standby |=> $stable(port_a_out) &&
    $stable(port_a_oe_n) && $stable(port_b_out) && $stable(port_b_oe_n)) else $error("pins moved");
  AST_HW_CLR: assert property (hw_standby |=> port_a_oe_n == 8'hFF &&
    port_b_oe_n == 8'hFF && port_b_pullup_on == 8'h00) else $error("standby not cleared");
  AST_PU_M13: assert property (m13 |=> port_b_pullup_on == 8'h00) else $error("pull-up on");
  AST_PU_EXCL: assert property ((port_b_pullup_on & ~port_b_oe_n) == 8'h00)
    else $error("pull-up on driven pin");
  AST_DIR_RD: assert property (s_axi_rvalid && raddr[15:1] == 15'h7FE0 |->
    s_axi_rdata == (raddr[0] ? 32'h0000FF00 : 32'h000000FF)) else $error("direction read");
  AST_UNMAP: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  C_ADDR: cover property (m13 && run);
  C_SLEEP: cover property (sw_standby);
  C_ERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // dpg_chk
bind dpg_top dpg_chk u_dpg_chk (.aclk, .aresetn, .op_mode, .hw_standby, .sw_standby, .addr_bus,
  .port_a_out, .port_a_oe_n, .port_b_out, .port_b_oe_n, .port_b_pullup_on, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// [dv/dual_port_addr_gpio_test.sv]
// self-checking bench for dpg_top: table of port setups, then reset, modes, standby, decode
// assumes dpg_pins models the board and axi4-lite answers without a fixed latency
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module dual_port_addr_gpio_test;
  // ea/eb: expected port a and port b read-back for the row's setup
  typedef struct {logic [2:0] m; logic [7:0] d, t, p, x, ea, eb;} dpg_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
  logic [2:0] op_mode = 3'h6;
  logic [15:0] addr_bus = 16'hC3A5;
  logic [7:0] ext = 8'h5A, rb;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rdat;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [7:0] port_a_in, port_b_in, port_a_out, port_a_oe_n, port_b_out, port_b_oe_n;
  wire [7:0] port_b_pullup_on;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_total = 0, n_checks = 0, cyc = 0;
  dpg_row_t rows[4] = '{'{3'h5, 8'hF0, 8'h3C, 8'h0F, 8'hA5, 8'h35, 8'hAC},
    '{3'h6, 8'h0F, 8'h5A, 8'hFF, 8'h00, 8'h0A, 8'h5F},
    '{3'h7, 8'hFF, 8'h81, 8'h00, 8'h7E, 8'h81, 8'h7E},
    '{3'h6, 8'h00, 8'hFF, 8'h55, 8'h00, 8'h00, 8'hFF}};
  always #4 aclk = ~aclk;
  dpg_top u_dpg_top (.aclk, .aresetn, .op_mode, .hw_standby, .sw_standby, .addr_bus, .port_a_in,
    .port_a_out, .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n, .port_b_pullup_on,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dpg_pins u_dpg_pins_a (.out(port_a_out), .oe_n(port_a_oe_n), .pu(8'h00), .ext(ext),
    .lvl(port_a_in));
  dpg_pins u_dpg_pins_b (.out(port_b_out), .oe_n(port_b_oe_n), .pu(port_b_pullup_on),
    .ext(ext), .lvl(port_b_in));
  // ==========================================
  // bus tasks and closing
  task automatic wr(input [31:0] a, input [7:0] d);
    bit ad = 1'b0;
    bit dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {4{d}};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rb = rdat[8*a[1:0] +: 8];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ~300 cycles of traffic expected; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ==========================================
  // main sequence
  initial begin : main
    logic [7:0] d, t, p, x;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      {d, t, p, x} = {rows[i].d, rows[i].t, rows[i].p, rows[i].x};
      op_mode <= rows[i].m;
      ext <= x;
      wr(32'hFFC0, d);
      wr(32'hFFC1, ~d);
      wr(32'hFFC2, t);
      wr(32'hFFC3, t);
      wr(32'hFFD8, p);
      `CHK(rsp, 2'h0)
      rd(32'hFFC2);
      `CHK(rb, rows[i].ea)
      rd(32'hFFC3);
      `CHK(rb, rows[i].eb)
      rd(32'hFFD8);
      `CHK(rb, p)
      `CHK(port_a_oe_n, ~d)
      `CHK(port_b_oe_n, d)
      `CHK(port_a_out & d, (rows[i].m == 3'h5 ? addr_bus[7:0] : t) & d)
      `CHK(port_b_out & ~d, (rows[i].m == 3'h5 ? addr_bus[15:8] : t) & ~d)
      `CHK(port_b_pullup_on, p & d)
      $display("row %0d done", i);
    end
    aresetn <= 1'b0;
    ext <= 8'h5A;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'hFFD8);
    `CHK(rb, 8'h00)
    rd(32'hFFC2);
    `CHK(rb, 8'h5A)
    `CHK({port_a_oe_n, port_b_oe_n, port_b_pullup_on}, 24'hFFFF00)
    wr(32'hFFC0, 8'hFF);
    wr(32'hFFC1, 8'hFF);
    rd(32'hFFC2);
    `CHK(rb, 8'h00)
    rd(32'hFFC3);
    `CHK(rb, 8'h00)
    $display("reset test done");
    // pull-ups armed on input pins, so the address modes must gate them off
    wr(32'hFFD8, 8'hFF);
    wr(32'hFFC1, 8'h00);
    for (int m = 1; m <= 3; m += 2) begin
      op_mode <= m[2:0];
      wr(32'hFFC0, 8'h00);
      rd(32'hFFC2);
      `CHK(rb, 8'h00)
      rd(32'hFFC0);
      `CHK(rdat, 32'h000000FF)
      rd(32'hFFC1);
      `CHK(rdat, 32'h0000FF00)
      `CHK({port_a_oe_n, port_b_oe_n, port_b_pullup_on}, 24'h0)
      `CHK({port_b_out, port_a_out}, addr_bus)
    end
    op_mode <= 3'h6;
    wr(32'hFFC2, 8'h55);
    `CHK(port_a_oe_n, 8'h00)
    $display("address mode test done");
    sw_standby <= 1'b1;
    // a mode change while asleep would move both ports if the pins were not frozen
    op_mode <= 3'h5;
    wr(32'hFFC2, 8'hAA);
    `CHK(port_a_out, 8'h55)
    `CHK(port_b_out, 8'h00)
    sw_standby <= 1'b0;
    op_mode <= 3'h6;
    rd(32'hFFC2);
    `CHK(rb, 8'h55)
    $display("sleep test done");
    wr(32'hFFD8, 8'hFF);
    wr(32'hFFC1, 8'h00);
    `CHK(port_b_pullup_on, 8'hFF)
    hw_standby <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK({port_a_oe_n, port_b_pullup_on}, 16'hFF00)
    hw_standby <= 1'b0;
    rd(32'hFFD8);
    `CHK(rb, 8'h00)
    rd(32'hFFC2);
    `CHK(rb, 8'h5A)
    $display("standby test done");
    rd(32'hFFC4);
    `CHK(rsp, 2'h2)
    wr(32'h0000FFD0, 8'h11);
    `CHK(rsp, 2'h2)
    rd(32'hABCDFFC1);
    `CHK({rsp, rdat}, 34'h00000FF00)
    $display("decode test done");
    tally_and_finish;
  end
endmodule // dual_port_addr_gpio_test
